/* pkg/telemetry_map.svh */
`ifndef TELEMETRY_MAP_SVH
`define TELEMETRY_MAP_SVH
// command codes
`define CMD_STORE_USER 8'h15
`define CMD_RESTORE_USER 8'h16
`define CMD_COMPARE_USER 8'hf0
`define CMD_MEM_UNLOCK 8'h2b
`define CMD_CLEAR_MAX_HOLDS 8'he3
`define CMD_DEVICE_RESET 8'hfd
`define CMD_SOURCE_SELECT 8'hd8
`define CMD_IIN 8'h89
`define CMD_IOUT 8'h8c
`define CMD_TEMP_EXT 8'h8d
`define CMD_TEMP_DIE 8'h8e
`define CMD_FREQ 8'h95
`define CMD_POUT 8'h96
`define CMD_PIN 8'h97
`define CMD_PIN_ACC 8'hac
`define CMD_IOUT_MAX 8'hd7
`define CMD_VOUT_MAX 8'hdd
`define CMD_VIN_MAX 8'hde
`define CMD_TEMP_EXT_MAX 8'hdf
`define CMD_IIN_MAX 8'he1
`define CMD_ICHIP 8'he4
`define CMD_TEMP_DIE_MAX 8'hf4
// unlock key and global address
`define UNLOCK_KEY 8'hc4
`define GLOBAL_ADDR 7'h5b
`define UNLOCK_ADDR_CMD 8'h2b
// source select codes
`define SEL_ROUND_ROBIN 4'h0
`define SEL_VIN 4'h1
`define SEL_ICHIP 4'h2
`define SEL_IIN 4'h3
`define SEL_TDIE 4'h4
`define SEL_VOUT0 4'h5
`define SEL_IOUT0 4'h6
`define SEL_TEXT0 4'h8
`define SEL_VOUT1 4'h9
`define SEL_IOUT1 4'ha
`define SEL_TEXT1 4'hc
// store thermal lockout, degrees C (L11 mantissa with exponent 0)
`define STORE_OFF_TEMP 16'sd130
`define STORE_ON_TEMP 16'sd125
// timing
`define CONV_PERIOD_MS 8
`define CORE_CLK_KHZ 200000
`define PIN_ACC_RESET 8'h32
`endif

/* pkg/telemetry_pkg.sv */
package telemetry_pkg;
	typedef enum logic [3:0] {
		SRC_VIN, SRC_ICHIP, SRC_IIN, SRC_TDIE, SRC_VOUT0, SRC_IOUT0, SRC_TEXT0,
		SRC_VOUT1, SRC_IOUT1, SRC_TEXT1, SRC_FREQ
	} source_t;
	typedef struct packed {
		logic valid;
		logic [3:0] src;
		logic [15:0] value;
	} sample_t;
	typedef struct packed {
		logic store;
		logic restore;
		logic compare;
	} nvm_req_t;
endpackage : telemetry_pkg

/* rtl/reading_store.sv */
`timescale 1ns/1ps
`default_nettype none
module reading_store #(
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic i_core_clk,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [15:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [DEPTH];
	always_ff @(posedge i_core_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule : reading_store
`default_nettype wire

/* rtl/telemetry_readback.sv */
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_map.svh"
module telemetry_readback #(
	parameter int CONV_CYCLES = `CORE_CLK_KHZ * `CONV_PERIOD_MS
) (
	// core
	input wire logic i_core_clk,
	input wire logic i_rst,
	// converter samples, core domain
	input wire telemetry_pkg::sample_t i_sample,
	input wire logic i_conv_done,
	input wire logic i_aux_only,
	// link, command side on link clock
	input wire logic i_link_clk,
	input wire logic [6:0] i_link_addr,
	input wire logic [7:0] i_link_cmd,
	input wire logic [7:0] i_link_data,
	input wire logic i_link_has_data,
	input wire logic i_link_strobe,
	// read data back to link, core domain word, link picks via handshake
	output logic [15:0] o_read_word,
	output logic o_read_valid,
	// converter steering
	output logic [3:0] o_conv_source,
	output logic o_conv_start,
	output logic o_single_mode,
	output logic o_faults_enable,
	output logic o_servo_enable,
	output logic o_cml_fault,
	output logic o_unlocked,
	output telemetry_pkg::nvm_req_t o_nvm_req
);
	////////////////////////////////////////////////////////////////////////////
	// link side capture
	logic [7:0] lk_cmd_ff;
	logic [7:0] lk_data_ff;
	logic [6:0] lk_addr_ff;
	logic lk_has_ff;
	logic lk_tog_ff;
	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			lk_cmd_ff <= 8'h00;
			lk_data_ff <= 8'h00;
			lk_addr_ff <= 7'h00;
			lk_has_ff <= 1'b0;
			lk_tog_ff <= 1'b0;
		end else if (i_link_strobe) begin
			lk_cmd_ff <= i_link_cmd;
			lk_data_ff <= i_link_data;
			lk_addr_ff <= i_link_addr;
			lk_has_ff <= i_link_has_data;
			lk_tog_ff <= ~lk_tog_ff;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// toggle crossing into core
	logic tog_s1_ff;
	logic tog_s2_ff;
	logic tog_s3_ff;
	logic cmd_ev;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			tog_s1_ff <= 1'b0;
			tog_s2_ff <= 1'b0;
			tog_s3_ff <= 1'b0;
		end else begin
			tog_s1_ff <= lk_tog_ff;
			tog_s2_ff <= tog_s1_ff;
			tog_s3_ff <= tog_s2_ff;
		end
	end
	assign cmd_ev = tog_s2_ff ^ tog_s3_ff;
	logic send_byte;
	logic write_byte;
	assign send_byte = cmd_ev && !lk_has_ff;
	assign write_byte = cmd_ev && lk_has_ff;
	////////////////////////////////////////////////////////////////////////////
	// unlock under auxiliary supply
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_unlocked <= 1'b0;
		end else if (write_byte && lk_addr_ff == `GLOBAL_ADDR && lk_cmd_ff == `UNLOCK_ADDR_CMD
			&& lk_data_ff == `UNLOCK_KEY) begin
			o_unlocked <= 1'b1;
		end
	end
	logic accept;
	assign accept = !i_aux_only || o_unlocked;
	////////////////////////////////////////////////////////////////////////////
	// source select register
	logic [7:0] sel_ff;
	logic reserved_sel;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_ff <= 8'h00;
		end else if (accept && write_byte && lk_cmd_ff == `CMD_SOURCE_SELECT) begin
			sel_ff <= lk_data_ff;
		end
	end
	always_comb begin
		case (sel_ff[3:0])
			`SEL_ROUND_ROBIN, `SEL_VIN, `SEL_ICHIP, `SEL_IIN, `SEL_TDIE, `SEL_VOUT0, `SEL_IOUT0,
			`SEL_TEXT0, `SEL_VOUT1, `SEL_IOUT1, `SEL_TEXT1: reserved_sel = (sel_ff[7:4] != 4'h0);
			default: reserved_sel = 1'b1;
		endcase
	end
	logic [3:0] eff_sel;
	assign eff_sel = reserved_sel ? `SEL_TDIE : sel_ff[3:0];
	////////////////////////////////////////////////////////////////////////////
	// conversion pacing and sequencing
	logic [$clog2(CONV_CYCLES+1)-1:0] pace_ff;
	logic [3:0] rr_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pace_ff <= '0;
			o_conv_start <= 1'b0;
		end else if (pace_ff == ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1)) begin
			pace_ff <= '0;
			o_conv_start <= 1'b1;
		end else begin
			pace_ff <= pace_ff + 1'b1;
			o_conv_start <= 1'b0;
		end
	end
	logic [$clog2(CONV_CYCLES+1):0] gap_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			gap_ff <= '0;
		end else if (o_conv_start) begin
			gap_ff <= '0;
		end else begin
			gap_ff <= gap_ff + 1'b1;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rr_ff <= 4'h0;
		end else if (i_conv_done) begin
			rr_ff <= (rr_ff == 4'(telemetry_pkg::SRC_FREQ)) ? 4'h0 : rr_ff + 4'h1;
		end
	end
	logic [3:0] nxt_src;
	always_comb begin
		case (eff_sel)
			`SEL_VIN: nxt_src = 4'(telemetry_pkg::SRC_VIN);
			`SEL_ICHIP: nxt_src = 4'(telemetry_pkg::SRC_ICHIP);
			`SEL_IIN: nxt_src = 4'(telemetry_pkg::SRC_IIN);
			`SEL_TDIE: nxt_src = 4'(telemetry_pkg::SRC_TDIE);
			`SEL_VOUT0: nxt_src = 4'(telemetry_pkg::SRC_VOUT0);
			`SEL_IOUT0: nxt_src = 4'(telemetry_pkg::SRC_IOUT0);
			`SEL_TEXT0: nxt_src = 4'(telemetry_pkg::SRC_TEXT0);
			`SEL_VOUT1: nxt_src = 4'(telemetry_pkg::SRC_VOUT1);
			`SEL_IOUT1: nxt_src = 4'(telemetry_pkg::SRC_IOUT1);
			`SEL_TEXT1: nxt_src = 4'(telemetry_pkg::SRC_TEXT1);
			default: nxt_src = rr_ff;
		endcase
	end
	// selection applied at the next conversion boundary
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_conv_source <= 4'h0;
			o_single_mode <= 1'b0;
			o_faults_enable <= 1'b1;
			o_servo_enable <= 1'b1;
		end else if (o_conv_start) begin
			o_conv_source <= nxt_src;
			o_single_mode <= (sel_ff != 8'h00);
			o_faults_enable <= (sel_ff == 8'h00);
			o_servo_enable <= (sel_ff == 8'h00);
		end
	end
	// repeated fault while selection reserved
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cml_fault <= 1'b0;
		end else begin
			o_cml_fault <= reserved_sel && o_conv_start;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// readings and max holds (values arrive already in L11 / L16)
	logic [15:0] rd [11];
	logic [15:0] pk [11];
	logic clear_pk;
	assign clear_pk = accept && send_byte && lk_cmd_ff == `CMD_CLEAR_MAX_HOLDS;
	function automatic logic signed [31:0] l11_val(input logic [15:0] w);
		logic signed [4:0] e;
		logic signed [31:0] m;
		e = w[15:11];
		m = 32'(signed'(w[10:0]));
		l11_val = (e >= 0) ? (m <<< e) : (m >>> (-e));
	endfunction : l11_val
	genvar g;
	generate
		for (g = 0; g < 11; g++) begin : g_src
			logic hit;
			logic greater;
			assign hit = i_sample.valid && i_sample.src == 4'(g);
			if (g == int'(telemetry_pkg::SRC_VOUT0) || g == int'(telemetry_pkg::SRC_VOUT1)) begin : g_u16
				assign greater = i_sample.value > pk[g];
			end else begin : g_l11
				assign greater = l11_val(i_sample.value) > l11_val(pk[g]);
			end
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					rd[g] <= 16'h0000;
				end else if (hit) begin
					rd[g] <= i_sample.value;
				end
			end
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					pk[g] <= 16'h0000;
				end else if (hit && (greater || clear_pk)) begin
					pk[g] <= i_sample.value;
				end else if (clear_pk) begin
					pk[g] <= 16'h0000;
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////
	// power words from products of latest readings, formed internally by mul_l11
	logic [15:0] pout_ff;
	logic [15:0] pin_ff;
	function automatic logic [15:0] mul_l11(input logic [15:0] a, input logic [15:0] b);
		logic signed [21:0] p;
		logic signed [5:0] e;
		p = 22'(signed'(a[10:0]) * signed'(b[10:0]));
		e = 6'(signed'(a[15:11])) + 6'(signed'(b[15:11])) + 6'sd10;
		mul_l11 = {e[4:0], p[20:10]};
	endfunction : mul_l11
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pout_ff <= 16'h0000;
		end else if (i_sample.valid && i_sample.src == 4'(telemetry_pkg::SRC_IOUT0)) begin
			pout_ff <= mul_l11({5'h1f, rd[telemetry_pkg::SRC_VOUT0][10:0]}, i_sample.value);
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_ff <= 16'h0000;
		end else begin
			pin_ff <= mul_l11(rd[telemetry_pkg::SRC_VIN], rd[telemetry_pkg::SRC_IIN]);
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// thermal lockout of store, restore and compare with hysteresis
	logic store_block_ff;
	logic signed [31:0] tdie;
	assign tdie = l11_val(rd[telemetry_pkg::SRC_TDIE]);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			store_block_ff <= 1'b0;
		end else if (tdie > 32'(`STORE_OFF_TEMP)) begin
			store_block_ff <= 1'b1;
		end else if (tdie < 32'(`STORE_ON_TEMP)) begin
			store_block_ff <= 1'b0;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_nvm_req <= '0;
		end else begin
			o_nvm_req.store <= accept && send_byte && lk_cmd_ff == `CMD_STORE_USER && !store_block_ff;
			o_nvm_req.restore <= accept && send_byte && lk_cmd_ff == `CMD_RESTORE_USER && !store_block_ff;
			o_nvm_req.compare <= accept && send_byte && lk_cmd_ff == `CMD_COMPARE_USER && !store_block_ff;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// read-back mux, answered three cycles after the command event (snapshot settles first)
	logic [15:0] nxt_word;
	logic rd_ev_ff;
	logic rd_ev2_ff;
	always_comb begin
		case (lk_cmd_ff)
			`CMD_IIN: nxt_word = rd[telemetry_pkg::SRC_IIN];
			`CMD_IOUT: nxt_word = rd[telemetry_pkg::SRC_IOUT0];
			`CMD_TEMP_EXT: nxt_word = rd[telemetry_pkg::SRC_TEXT0];
			`CMD_TEMP_DIE: nxt_word = rd[telemetry_pkg::SRC_TDIE];
			`CMD_FREQ: nxt_word = rd[telemetry_pkg::SRC_FREQ];
			`CMD_POUT: nxt_word = pout_ff;
			`CMD_PIN: nxt_word = pin_ff;
			`CMD_PIN_ACC: nxt_word = {8'h00, `PIN_ACC_RESET};
			`CMD_IOUT_MAX: nxt_word = pk[telemetry_pkg::SRC_IOUT0];
			`CMD_VOUT_MAX: nxt_word = pk[telemetry_pkg::SRC_VOUT0];
			`CMD_VIN_MAX: nxt_word = pk[telemetry_pkg::SRC_VIN];
			`CMD_TEMP_EXT_MAX: nxt_word = pk[telemetry_pkg::SRC_TEXT0];
			`CMD_IIN_MAX: nxt_word = pk[telemetry_pkg::SRC_IIN];
			`CMD_ICHIP: nxt_word = rd[telemetry_pkg::SRC_ICHIP];
			`CMD_TEMP_DIE_MAX: nxt_word = pk[telemetry_pkg::SRC_TDIE];
			default: nxt_word = 16'h0000;
		endcase
	end
	logic [15:0] snap_word;
	reading_store #(.DEPTH(2), .AW(1)) u_snap (
		.i_core_clk(i_core_clk),
		.i_we(cmd_ev && accept),
		.i_waddr(1'b0),
		.i_wdata(nxt_word),
		.i_raddr(1'b0),
		.o_rdata(snap_word)
	);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_ev_ff <= 1'b0;
			rd_ev2_ff <= 1'b0;
			o_read_valid <= 1'b0;
			o_read_word <= 16'h0000;
		end else begin
			rd_ev_ff <= cmd_ev && accept && !lk_has_ff;
			rd_ev2_ff <= rd_ev_ff;
			o_read_valid <= rd_ev2_ff;
			if (rd_ev2_ff) begin
				o_read_word <= snap_word;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence conv_edge_s;
		o_conv_start;
	endsequence
	store_hot_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		store_block_ff |=> !o_nvm_req.store) else $error("store issued while hot");
	single_mode_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		conv_edge_s and sel_ff != 8'h00 |=> !o_faults_enable && !o_servo_enable)
		else $error("faults not disabled");
	rr_mode_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		conv_edge_s and sel_ff == 8'h00 |=> o_faults_enable) else $error("faults not restored");
	reserved_fault_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		conv_edge_s and reserved_sel |=> o_cml_fault) else $error("no fault on reserved");
	reserved_src_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		conv_edge_s and reserved_sel |=> o_conv_source == 4'(telemetry_pkg::SRC_TDIE))
		else $error("reserved not die temp");
	clear_pk_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		clear_pk && !i_sample.valid |=> pk[telemetry_pkg::SRC_TDIE] == 16'h0000)
		else $error("peak not cleared");
	peak_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!clear_pk |=> l11_val(pk[telemetry_pkg::SRC_TDIE]) >= l11_val($past(pk[telemetry_pkg::SRC_TDIE])))
		else $error("peak decreased");
	select_latency_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		gap_ff <= ($clog2(CONV_CYCLES+1)+1)'(CONV_CYCLES)) else $error("conversion stalled");
	read_answer_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		cmd_ev && accept && !lk_has_ff |-> ##3 o_read_valid) else $error("read not answered");
endmodule : telemetry_readback
`default_nettype wire

/* verification/link_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
	// reset, the link clock runs while it is high
	input wire logic i_rst,
	// link side of the device
	output logic o_link_clk,
	output logic [6:0] o_addr,
	output logic [7:0] o_cmd,
	output logic [7:0] o_data,
	output logic o_has_data,
	output logic o_strobe
);
	logic run;
	initial begin
		run = 1'b0;
		o_link_clk = 1'b0;
		o_addr = 7'h00;
		o_cmd = 8'h00;
		o_data = 8'h00;
		o_has_data = 1'b0;
		o_strobe = 1'b0;
	end
	// link clock only stands still outside frames
	always begin
		if (run || i_rst) begin
			#3 o_link_clk = ~o_link_clk;
		end else begin
			@(run or i_rst);
		end
	end
	// one transaction; has_data low is a send byte or a read
	task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic h);
		run = 1'b1;
		repeat (2) @(negedge o_link_clk);
		o_addr = a;
		o_cmd = c;
		o_data = d;
		o_has_data = h;
		o_strobe = 1'b1;
		@(negedge o_link_clk);
		o_strobe = 1'b0;
		o_addr = ~a;
		o_cmd = ~c;
		o_data = ~d;
		repeat (4) @(negedge o_link_clk);
		run = 1'b0;
	endtask : xfer
endmodule : link_host_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_map.svh"
module tb_top;
	localparam int CONV = 50;
	localparam logic [6:0] DEV_ADDR = 7'h40;
	logic i_core_clk;
	logic i_rst;
	telemetry_pkg::sample_t i_sample;
	logic i_conv_done;
	logic i_aux_only;
	logic link_clk;
	logic [6:0] link_addr;
	logic [7:0] link_cmd;
	logic [7:0] link_data;
	logic link_has;
	logic link_strobe;
	logic [15:0] o_read_word;
	logic o_read_valid;
	logic [3:0] o_conv_source;
	logic o_conv_start;
	logic o_single_mode;
	logic o_faults_enable;
	logic o_servo_enable;
	logic o_cml_fault;
	logic o_unlocked;
	telemetry_pkg::nvm_req_t o_nvm_req;
	int bad_count = 0;
	int tests_run = 0;
	int seed = 58117;
	int rv_cnt = 0;
	int cml_cnt = 0;
	int nvm_cnt[3] = '{0, 0, 0};
	logic [15:0] last_word;
	telemetry_pkg::source_t srcs[8] = '{telemetry_pkg::SRC_IIN, telemetry_pkg::SRC_IOUT0,
		telemetry_pkg::SRC_TEXT0, telemetry_pkg::SRC_TDIE, telemetry_pkg::SRC_FREQ,
		telemetry_pkg::SRC_ICHIP, telemetry_pkg::SRC_VIN, telemetry_pkg::SRC_VOUT0};
	logic [7:0] rdc[8] = '{`CMD_IIN, `CMD_IOUT, `CMD_TEMP_EXT, `CMD_TEMP_DIE, `CMD_FREQ, `CMD_ICHIP, 8'h00, 8'h00};
	logic [7:0] mxc[8] = '{`CMD_IIN_MAX, `CMD_IOUT_MAX, `CMD_TEMP_EXT_MAX, `CMD_TEMP_DIE_MAX, 8'h00, 8'h00,
		`CMD_VIN_MAX, `CMD_VOUT_MAX};
	logic [7:0] codes[16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0c,
		8'h07, 8'h0b, 8'h0d, 8'h0e, 8'h0f, 8'h80};
	logic [7:0] nvm_cmds[3] = '{`CMD_STORE_USER, `CMD_RESTORE_USER, `CMD_COMPARE_USER};

	telemetry_readback #(.CONV_CYCLES(CONV)) dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_sample(i_sample), .i_conv_done(i_conv_done), .i_aux_only(i_aux_only), .i_link_clk(link_clk),
		.i_link_addr(link_addr), .i_link_cmd(link_cmd), .i_link_data(link_data),
		.i_link_has_data(link_has), .i_link_strobe(link_strobe), .o_read_word(o_read_word),
		.o_read_valid(o_read_valid), .o_conv_source(o_conv_source), .o_conv_start(o_conv_start),
		.o_single_mode(o_single_mode), .o_faults_enable(o_faults_enable), .o_servo_enable(o_servo_enable),
		.o_cml_fault(o_cml_fault), .o_unlocked(o_unlocked), .o_nvm_req(o_nvm_req));
	link_host_model host_u (.i_rst(i_rst), .o_link_clk(link_clk), .o_addr(link_addr), .o_cmd(link_cmd),
		.o_data(link_data), .o_has_data(link_has), .o_strobe(link_strobe));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end
	// converter: a result follows every start
	always @(negedge i_core_clk) i_conv_done <= (o_conv_start === 1'b1);
	always @(posedge i_core_clk) begin
		if (o_read_valid === 1'b1) begin
			rv_cnt++;
			last_word = o_read_word;
		end
		if (o_cml_fault === 1'b1) cml_cnt++;
		if (o_nvm_req.store === 1'b1) nvm_cnt[0]++;
		if (o_nvm_req.restore === 1'b1) nvm_cnt[1]++;
		if (o_nvm_req.compare === 1'b1) nvm_cnt[2]++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic put(input telemetry_pkg::source_t s, input logic [15:0] v);
		@(negedge i_core_clk);
		i_sample = {1'b1, s, v};
		@(negedge i_core_clk);
		i_sample.valid = 1'b0;
	endtask : put
	task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic got, output logic [15:0] w);
		int n;
		n = rv_cnt;
		host_u.xfer(a, c, 8'h00, 1'b0);
		got = 1'b0;
		for (int k = 0; k < 40 && !got; k++) begin
			@(negedge i_core_clk);
			got = (rv_cnt != n);
		end
		w = last_word;
	endtask : rd
	task automatic snd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input logic h);
		host_u.xfer(a, c, d, h);
		repeat (30) @(negedge i_core_clk);
	endtask : snd
	task automatic wait_start();
		int k;
		k = 0;
		do begin
			@(negedge i_core_clk);
			k++;
		end while (o_conv_start !== 1'b1 && k < 4 * CONV);
		check(k < 4 * CONV, 1, "conversion start");
	endtask : wait_start
	// power word against the exact product, allowing the truncated low mantissa bits
	function automatic bit pow_ok(input logic [15:0] w, input int prod, input int scale);
		int v;
		v = int'(signed'(w[10:0]));
		v = (w[15] == 1'b0) ? (v <<< w[14:11]) : (v >>> (5'd0 - w[15:11]));
		return (prod - scale * v) inside {[0:1023]};
	endfunction : pow_ok
	function automatic logic [3:0] exp_src(input logic [7:0] c);
		case (c)
			8'h01: return telemetry_pkg::SRC_VIN;
			8'h02: return telemetry_pkg::SRC_ICHIP;
			8'h03: return telemetry_pkg::SRC_IIN;
			8'h05: return telemetry_pkg::SRC_VOUT0;
			8'h06: return telemetry_pkg::SRC_IOUT0;
			8'h08: return telemetry_pkg::SRC_TEXT0;
			8'h09: return telemetry_pkg::SRC_VOUT1;
			8'h0a: return telemetry_pkg::SRC_IOUT1;
			8'h0c: return telemetry_pkg::SRC_TEXT1;
			default: return telemetry_pkg::SRC_TDIE;
		endcase
	endfunction : exp_src

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200us;
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		finish_test();
	end
	initial begin
		logic got;
		logic [15:0] w;
		logic [15:0] r;
		logic [15:0] hi[8];
		logic [15:0] lo[8];
		logic [15:0] mask;
		int n;
		i_rst = 1'b1;
		i_sample = '0;
		i_conv_done = 1'b0;
		i_aux_only = 1'b0;
		repeat (16) @(negedge i_core_clk);
		i_rst = 1'b0;
		check({o_faults_enable, o_servo_enable, o_single_mode, o_unlocked, o_nvm_req}, 16'h0060, "reset");
		snd(DEV_ADDR, `CMD_DEVICE_RESET, 8'h00, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			r = 16'($random(seed));
			hi[i] = (i == 7) ? (16'hf000 | r) : (16'h0200 | (r & 16'h01ff));
			lo[i] = r & 16'h00ff;
			put(srcs[i], hi[i]);
			put(srcs[i], lo[i]);
			if (rdc[i] != 8'h00) begin
				rd(DEV_ADDR, rdc[i], got, w);
				check(w, lo[i], "reading");
			end
			if (mxc[i] != 8'h00) begin
				rd(DEV_ADDR, mxc[i], got, w);
				check(w, hi[i], "max hold");
			end
		end
		snd(DEV_ADDR, `CMD_CLEAR_MAX_HOLDS, 8'h00, 1'b0);
		for (int i = 0; i < 8; i++) begin
			if (mxc[i] != 8'h00) begin
				put(srcs[i], lo[i]);
				rd(DEV_ADDR, mxc[i], got, w);
				check(w, lo[i], "max hold after clear");
			end
		end
		rd(DEV_ADDR, `CMD_PIN, got, w);
		check(got, 1, "input power answered");
		check(pow_ok(w, int'(lo[6]) * int'(lo[0]), 1), 1, "input power value");
		rd(DEV_ADDR, `CMD_POUT, got, w);
		check(got, 1, "output power answered");
		check(pow_ok(w, int'(lo[7]) * int'(lo[1]), 2), 1, "output power value");
		rd(DEV_ADDR, `CMD_PIN_ACC, got, w);
		check(w[7:0], `PIN_ACC_RESET, "power accuracy");
		$display("test readings done");
		for (int i = 0; i < 16; i++) begin
			n = cml_cnt;
			snd(DEV_ADDR, `CMD_SOURCE_SELECT, codes[i], 1'b1);
			repeat ((codes[i] == 8'h08 || codes[i] == 8'h0c) ? 4 : 3) wait_start();
			check(o_conv_source, exp_src(codes[i]), "selected source");
			wait_start();
			check(o_conv_source, exp_src(codes[i]), "source repeats");
			check({o_single_mode, o_faults_enable, o_servo_enable}, 3'b100, "single mode");
			check((cml_cnt - n >= 2) == (i >= 10), 1, "reserved fault");
		end
		snd(DEV_ADDR, `CMD_SOURCE_SELECT, 8'h00, 1'b1);
		repeat (3) wait_start();
		mask = '0;
		for (int i = 0; i < 24; i++) begin
			wait_start();
			mask[o_conv_source] = 1'b1;
		end
		check(mask[9:0], 16'h03ff, "round robin");
		check({o_single_mode, o_faults_enable, o_servo_enable}, 3'b011, "round robin mode");
		$display("test selection done");
		put(telemetry_pkg::SRC_TDIE, 16'h003c);
		for (int i = 0; i < 3; i++) begin
			n = nvm_cnt[i];
			snd(DEV_ADDR, nvm_cmds[i], 8'h00, 1'b0);
			check(nvm_cnt[i] - n, 1, "memory request");
		end
		foreach (hi[i]) begin
			hi[i] = (i == 0) ? 16'h0083 : (i == 1) ? 16'h007f : 16'h007c;
			if (i < 3) begin
				put(telemetry_pkg::SRC_TDIE, hi[i]);
				n = nvm_cnt[0];
				snd(DEV_ADDR, `CMD_STORE_USER, 8'h00, 1'b0);
				check(nvm_cnt[0] - n, (i == 2), "store lockout");
			end
		end
		$display("test memory done");
		@(negedge i_core_clk);
		i_aux_only = 1'b1;
		rd(DEV_ADDR, `CMD_IIN, got, w);
		check(got, 0, "locked read refused");
		snd(`GLOBAL_ADDR, `CMD_MEM_UNLOCK, 8'hc3, 1'b1);
		check(o_unlocked, 0, "wrong key");
		snd(`GLOBAL_ADDR, `CMD_MEM_UNLOCK, `UNLOCK_KEY, 1'b1);
		check(o_unlocked, 1, "unlock");
		rd(DEV_ADDR, `CMD_IIN, got, w);
		check(got, 1, "unlocked read");
		i_aux_only = 1'b0;
		$display("test unlock done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
